// >>> shared/mie_pkg.sv
// Shared constants and types of the move-instruction execute block.
package mie_pkg;

	// Word and address widths, and file depth.
	localparam int MIE_IW = 14;
	localparam int MIE_DW = 8;
	localparam int MIE_AW = 7;
	localparam int MIE_DEPTH = 128;

	// Field positions inside the instruction word.
	localparam int MIE_TOP_BIT = 13;
	localparam int MIE_LOAD_LO = 10;
	localparam int MIE_COPY_LO = 8;
	localparam int MIE_STORE_LO = 7;
	localparam int MIE_DEST_BIT = 7;

	// Opcode patterns, compared on the bits from the top down to the _LO bit.
	localparam logic [3:0] MIE_LOAD_PAT = 4'hc;
	localparam logic [5:0] MIE_COPY_PAT = 6'h08;
	localparam logic [6:0] MIE_STORE_PAT = 7'h01;

	// Reset values.
	localparam logic [7:0] MIE_W_RST = 8'h00;
	localparam logic MIE_Z_RST = 1'b0;
	localparam logic [7:0] MIE_DATA_RST = 8'h00;

	// Phases of one instruction cycle, one ref_clk cycle each.
	localparam int MIE_PHASES = 4;

	typedef enum logic [1:0] {
		MIE_Q1,
		MIE_Q2,
		MIE_Q3,
		MIE_Q4
	} mie_phase_e;

	typedef enum logic [1:0] {
		MIE_OP_NONE,
		MIE_OP_LOAD,
		MIE_OP_COPY,
		MIE_OP_STORE
	} mie_op_e;

	typedef struct packed {
		mie_op_e op;
		logic dest;
		logic [MIE_AW-1:0] addr;
		logic [MIE_DW-1:0] lit;
	} mie_instr_s;

	localparam mie_instr_s MIE_INSTR_RST = '{
		op: MIE_OP_NONE,
		dest: 1'b0,
		addr: 7'h00,
		lit: 8'h00
	};

endpackage

// >>> verilog/mie_file_ram.sv
// File register array with one write port and a registered read port.
`timescale 1ns/10ps
`default_nettype none

module mie_file_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Write port.
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read port.
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdata_reg;
	logic [WIDTH-1:0] rdata_next;

	always_comb begin
		rdata_next = mem[raddr];
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;

endmodule

`default_nettype wire

// >>> verilog/mie_core.sv
// Decode and execute of the literal-load, file-copy and store-working ops.
`timescale 1ns/10ps
`default_nettype none

module mie_core import mie_pkg::*; #(
	parameter int DEPTH = MIE_DEPTH
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Instruction fetch.
	input wire logic instr_valid,
	input wire logic [MIE_IW-1:0] instr_word,
	output logic instr_ready,
	// Core state.
	output logic [MIE_DW-1:0] w_out,
	output logic z_out,
	output logic done
);

	mie_phase_e phase_reg;
	mie_phase_e phase_next;
	mie_instr_s ir_reg;
	mie_instr_s ir_next;
	mie_instr_s dec;
	logic [MIE_DW-1:0] data_reg;
	logic [MIE_DW-1:0] data_next;
	logic zero_reg;
	logic zero_next;
	logic [MIE_DW-1:0] w_reg;
	logic [MIE_DW-1:0] w_next;
	logic z_reg;
	logic z_next;
	logic done_reg;
	logic done_next;
	logic accept;
	logic file_we;
	logic [MIE_DW-1:0] ram_rdata;

	// Decode of the word offered by the fetch stage.
	always_comb begin
		dec = MIE_INSTR_RST;
		dec.dest = instr_word[MIE_DEST_BIT];
		dec.addr = instr_word[MIE_AW-1:0];
		dec.lit = instr_word[MIE_DW-1:0];
		if (instr_word[MIE_TOP_BIT:MIE_LOAD_LO] == MIE_LOAD_PAT) begin
			dec.op = MIE_OP_LOAD;
		end else if (instr_word[MIE_TOP_BIT:MIE_COPY_LO] == MIE_COPY_PAT) begin
			dec.op = MIE_OP_COPY;
		end else if (instr_word[MIE_TOP_BIT:MIE_STORE_LO] == MIE_STORE_PAT) begin
			dec.op = MIE_OP_STORE;
		end
	end

	assign instr_ready = (phase_reg == MIE_Q1);
	assign accept = instr_ready && instr_valid;

	// Write port of the file array, used only in the fourth phase.
	assign file_we = (phase_reg == MIE_Q4) &&
		((ir_reg.op == MIE_OP_COPY && ir_reg.dest) ||
		(ir_reg.op == MIE_OP_STORE));

	mie_file_ram #(
		.WIDTH(MIE_DW),
		.DEPTH(DEPTH),
		.AW(MIE_AW)
	) u_file_ram (
		.clk(ref_clk),
		.rst_n(rst_n),
		.we(file_we),
		.waddr(ir_reg.addr),
		.wdata(data_reg),
		.raddr(dec.addr),
		.rdata(ram_rdata)
	);

	// Phase sequencing and execution.
	always_comb begin
		phase_next = phase_reg;
		ir_next = ir_reg;
		data_next = data_reg;
		zero_next = zero_reg;
		w_next = w_reg;
		z_next = z_reg;
		done_next = 1'b0;
		case (phase_reg)
			MIE_Q1: begin
				phase_next = MIE_Q2;
				if (accept) begin
					ir_next = dec;
				end else begin
					ir_next = MIE_INSTR_RST;
				end
			end
			MIE_Q2: begin
				phase_next = MIE_Q3;
				case (ir_reg.op)
					MIE_OP_LOAD: data_next = ir_reg.lit;
					MIE_OP_COPY: data_next = ram_rdata;
					MIE_OP_STORE: data_next = w_reg;
					default: data_next = data_reg;
				endcase
			end
			MIE_Q3: begin
				phase_next = MIE_Q4;
				zero_next = (data_reg == MIE_DATA_RST);
			end
			MIE_Q4: begin
				phase_next = MIE_Q1;
				done_next = (ir_reg.op != MIE_OP_NONE);
				if (ir_reg.op == MIE_OP_LOAD) begin
					w_next = data_reg;
				end
				if (ir_reg.op == MIE_OP_COPY) begin
					z_next = zero_reg;
					if (!ir_reg.dest) begin
						w_next = data_reg;
					end
				end
			end
			default: begin
				phase_next = MIE_Q1;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= MIE_Q1;
			ir_reg <= MIE_INSTR_RST;
			data_reg <= MIE_DATA_RST;
			zero_reg <= 1'b0;
			w_reg <= MIE_W_RST;
			z_reg <= MIE_Z_RST;
			done_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			ir_reg <= ir_next;
			data_reg <= data_next;
			zero_reg <= zero_next;
			w_reg <= w_next;
			z_reg <= z_next;
			done_reg <= done_next;
		end
	end

	assign w_out = w_reg;
	assign z_out = z_reg;
	assign done = done_reg;

	// Checks on the executed behaviour.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_load_literal: assert property (
		accept && dec.op == MIE_OP_LOAD
		|-> ##4 w_out == $past(instr_word[MIE_DW-1:0], 4)
	) else $error("Literal did not reach W.");

	a_spare_bits: assert property (
		instr_word[MIE_TOP_BIT:MIE_LOAD_LO] == MIE_LOAD_PAT
		|-> dec.op == MIE_OP_LOAD
	) else $error("Literal-load not decoded with spare bits set.");

	a_copy_to_w: assert property (
		accept && dec.op == MIE_OP_COPY && !dec.dest
		|-> ##4 w_out == $past(ram_rdata, 3)
	) else $error("File-copy to W moved the wrong value.");

	a_copy_writeback: assert property (
		accept && dec.op == MIE_OP_COPY && dec.dest
		|-> ##3 file_we && data_reg == $past(ram_rdata, 2)
			&& ir_reg.addr == $past(instr_word[MIE_AW-1:0], 3)
			##1 w_out == $past(w_out, 4)
	) else $error("File-copy write-back went wrong.");

	a_zero_flag: assert property (
		accept && dec.op == MIE_OP_COPY
		|-> ##4 z_out == ($past(ram_rdata, 3) == MIE_DATA_RST)
	) else $error("Zero flag wrong after file-copy.");

	a_store_write: assert property (
		accept && dec.op == MIE_OP_STORE
		|-> ##3 file_we && data_reg == w_out
			&& ir_reg.addr == $past(instr_word[MIE_AW-1:0], 3)
	) else $error("Store did not write W into the register.");

	a_phase_order: assert property (
		phase_reg == MIE_Q1
		|=> phase_reg == MIE_Q2 ##1 phase_reg == MIE_Q3
			##1 phase_reg == MIE_Q4 ##1 phase_reg == MIE_Q1
	) else $error("Phases out of order.");

	a_flags_kept: assert property (
		accept && dec.op != MIE_OP_COPY
		|-> ##4 z_out == $past(z_out, 4)
	) else $error("Flag changed by a flag-neutral op.");

	a_one_cycle: assert property (
		accept && dec.op != MIE_OP_NONE
		|=> !done [*3] ##1 done ##1 !done
	) else $error("Instruction did not finish in one cycle.");

endmodule

`default_nettype wire

// >>> tb/test_move_instruction_execute.sv
// Self-checking bench of the move-instruction execute core.
`timescale 1ns/10ps
`default_nettype none

module test_move_instruction_execute import mie_pkg::*;;
	logic ref_clk;
	logic rst_n;
	logic instr_valid;
	logic [MIE_IW-1:0] instr_word;
	logic instr_ready;
	logic [MIE_DW-1:0] w_out;
	logic z_out;
	logic done;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;

	mie_core #(.DEPTH(MIE_DEPTH)) DUT (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.instr_ready(instr_ready),
		.w_out(w_out),
		.z_out(z_out),
		.done(done)
	);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	function automatic logic [13:0] ld(input logic [7:0] k, input logic [1:0] x);
		return {MIE_LOAD_PAT, x, k};
	endfunction

	function automatic logic [13:0] cp(input logic d, input logic [6:0] f);
		return {MIE_COPY_PAT, d, f};
	endfunction

	function automatic logic [13:0] st(input logic [6:0] f);
		return {MIE_STORE_PAT, f};
	endfunction

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk8(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Issues one word in Q1 and judges the outputs four cycles later.
	task automatic exec(input logic [13:0] word, input logic exp_done,
			input logic [7:0] exp_w, input logic exp_z);
		int n;
		n = 0;
		while (instr_ready !== 1'b1 && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		chk1("instr_ready", 1'b1, instr_ready);
		instr_valid = 1'b1;
		instr_word = word;
		@(negedge ref_clk);
		instr_valid = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk1("done", exp_done, done);
		chk8("w_out", exp_w, w_out);
		chk1("z_out", exp_z, z_out);
	endtask

	task automatic t_reset;
		chk1("instr_ready", 1'b1, instr_ready);
		chk1("done", 1'b0, done);
		chk8("w_out", 8'h00, w_out);
		chk1("z_out", 1'b0, z_out);
		$display("test reset done");
	endtask

	task automatic t_load;
		for (int i = 0; i < 4; i++) begin
			exec(ld(8'h5a + 8'(i), 2'(i)), 1'b1, 8'h5a + 8'(i), 1'b0);
		end
		exec(ld(8'h00, 2'h0), 1'b1, 8'h00, 1'b0);
		$display("test load done");
	endtask

	task automatic t_copy;
		exec(ld(8'ha5, 2'h0), 1'b1, 8'ha5, 1'b0);
		exec(st(7'h7f), 1'b1, 8'ha5, 1'b0);
		exec(ld(8'h00, 2'h0), 1'b1, 8'h00, 1'b0);
		exec(st(7'h00), 1'b1, 8'h00, 1'b0);
		exec(ld(8'h3c, 2'h0), 1'b1, 8'h3c, 1'b0);
		exec(cp(1'b1, 7'h00), 1'b1, 8'h3c, 1'b1);
		exec(ld(8'h33, 2'h3), 1'b1, 8'h33, 1'b1);
		exec(cp(1'b0, 7'h7f), 1'b1, 8'ha5, 1'b0);
		exec(ld(8'h11, 2'h0), 1'b1, 8'h11, 1'b0);
		exec(cp(1'b1, 7'h7f), 1'b1, 8'h11, 1'b0);
		exec(cp(1'b0, 7'h00), 1'b1, 8'h00, 1'b1);
		exec(st(7'h7f), 1'b1, 8'h00, 1'b1);
		exec(cp(1'b0, 7'h7f), 1'b1, 8'h00, 1'b1);
		$display("test copy done");
	endtask

	task automatic t_none;
		exec(14'h3fff, 1'b0, 8'h00, 1'b1);
		exec(14'h0005, 1'b0, 8'h00, 1'b1);
		// A word offered only outside the first phase is never taken.
		@(negedge ref_clk);
		instr_valid = 1'b1;
		instr_word = ld(8'hee, 2'h0);
		repeat (3) @(negedge ref_clk);
		instr_valid = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk1("done", 1'b0, done);
		chk8("w_out", 8'h00, w_out);
		chk1("z_out", 1'b1, z_out);
		$display("test none done");
	endtask

	task automatic t_midreset;
		rst_n = 1'b0;
		@(negedge ref_clk);
		t_reset();
		rst_n = 1'b1;
		exec(ld(8'h77, 2'h0), 1'b1, 8'h77, 1'b0);
		$display("test midreset done");
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 1000) begin
			mismatches++;
			finish_test();
		end
	end

	initial begin
		rst_n = 1'b0;
		instr_valid = 1'b0;
		instr_word = '0;
		repeat (4) @(negedge ref_clk);
		t_reset();
		rst_n = 1'b1;
		t_load();
		t_copy();
		t_none();
		t_midreset();
		finish_test();
	end
endmodule

`default_nettype wire
